// ===== verilog/rtcpc_pkg.sv
// Purpose: constants shared by the real-time counter and periodic timer
// Assumes: 32-bit apb, byte addresses, one word per register
// Notes:   all offsets, fields, reset values and counts live here
`default_nettype none
package rtcpc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_COUNTER_CONTROL_A    = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_INTCTRL  = 8'h08;
  localparam logic [7:0] ADDR_INTERRUPT_FLAG_REGISTER = 8'h0c;
  localparam logic [7:0] ADDR_COUNT    = 8'h10;
  localparam logic [7:0] ADDR_PERIOD   = 8'h14;
  localparam logic [7:0] ADDR_COMPARE  = 8'h18;
  localparam logic [7:0] ADDR_EVCTRL   = 8'h1c;
  localparam logic [7:0] ADDR_PITCTRL  = 8'h20;
  localparam logic [7:0] ADDR_PITINTEN = 8'h24;
  localparam logic [7:0] ADDR_PITFLAGS = 8'h28;
  localparam logic [7:0] ADDR_OSCCTRL  = 8'h2c;
  localparam logic [7:0] ADDR_MCLKSTAT = 8'h30;
  localparam logic [7:0] ADDR_PROTECT  = 8'h34;
  // counter_control_a fields
  localparam int COUNTER_CONTROL_A_EN_BIT    = 0;
  localparam int COUNTER_CONTROL_A_PRESC_LSB = 3;
  localparam int COUNTER_CONTROL_A_STDBY_BIT = 7;
  // flag and enable positions (intctrl, interrupt_flag_register, evctrl)
  localparam int WRAP_BIT = 0;
  localparam int CMP_BIT  = 1;
  localparam int PITEV_BIT    = 2;
  localparam int EVSEL_LSB    = 4;
  // periodic_timer_control fields
  localparam int PIT_EN_BIT   = 0;
  localparam int PIT_CODE_LSB = 3;
  localparam logic [3:0] PIT_CODE_OFF  = 4'h0;
  localparam logic [3:0] PIT_CODE_RSVD = 4'hf;
  localparam logic [4:0] PIT_EV_BASE   = 5'h06;
  // crystal_osc_control fields
  localparam int OSC_EN_BIT    = 0;
  localparam int OSC_STDBY_BIT = 1;
  localparam int OSC_SEL_BIT   = 2;
  localparam int OSC_CRYSTAL_STARTUP_TIME_LSB  = 4;
  localparam int OSC_STABLE_BIT = 6;
  // reset values and counts
  localparam logic [15:0] PERIOD_RST  = 16'hffff;
  localparam logic [1:0]  SYNC_TICKS  = 2'h2;
  localparam logic [7:0]  PROT_KEY    = 8'hd8;
  localparam logic [2:0]  PROT_WIN    = 3'h4;
  localparam logic [16:0] STARTUP_MIN = 17'h00100;
  localparam int PRESC_W = 15;
  // busy index per synchronised register
  localparam int BUSY_COUNTER_CONTROL_A = 0;
  localparam int BUSY_CNT   = 1;
  localparam int BUSY_PER   = 2;
  localparam int BUSY_CMP   = 3;
endpackage
`default_nettype wire

// ===== verilog/rtcpc_core_if.sv
// Purpose: settings and events between register side and counter core
// Assumes: single clock, tick is a one-cycle enable
// Notes:   ctl drives settings, core returns count and event pulses
`default_nettype none
interface rtcpc_core_if;
  logic        tick;
  logic        rtc_en;
  logic        pit_en;
  logic        ev_pit_en;
  logic [3:0]  presc;
  logic [3:0]  pit_code;
  logic [2:0]  ev_code;
  logic [15:0] per;
  logic [15:0] cmp;
  logic        load;
  logic [15:0] load_val;
  logic [15:0] cnt;
  logic        ovf_p;
  logic        cmp_p;
  logic        pit_p;
  logic        pit_ev_p;
  modport ctl (output tick, rtc_en, pit_en, ev_pit_en, presc, pit_code,
               ev_code, per, cmp, load, load_val,
               input cnt, ovf_p, cmp_p, pit_p, pit_ev_p);
  modport core (input tick, rtc_en, pit_en, ev_pit_en, presc, pit_code,
                ev_code, per, cmp, load, load_val,
                output cnt, ovf_p, cmp_p, pit_p, pit_ev_p);
endinterface
`default_nettype wire

// ===== verilog/rtcpc_core.sv
// Purpose: shared prescaler, count register and periodic tap
// Assumes: tick is one cycle per low-speed clock period
// Notes:   event pulses are one system clock wide
`default_nettype none
module rtcpc_core
  import rtcpc_pkg::*;
(
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   srst,
  // settings and events
  rtcpc_core_if.core  c
);
  logic [PRESC_W-1:0] presc_reg;
  logic [15:0]        cnt_reg;
  logic               run;
  logic               cnt_step;
  logic               pit_hit;
  logic               ev_hit;

  // ones in every bit below n
  function automatic logic [PRESC_W-1:0] low_mask(input logic [4:0] n);
    logic [15:0] m;
    m = (16'h0001 << n) - 16'h0001;
    return m[PRESC_W-1:0];
  endfunction

  assign run      = c.rtc_en | c.pit_en;
  assign cnt_step = c.tick & c.rtc_en &
                    ((presc_reg & low_mask({1'b0, c.presc})) ==
                     low_mask({1'b0, c.presc}));
  assign pit_hit  = c.tick & c.pit_en & (c.pit_code != PIT_CODE_OFF) &
                    (c.pit_code != PIT_CODE_RSVD) &
                    ((presc_reg & low_mask({1'b0, c.pit_code} + 5'h01)) ==
                     low_mask({1'b0, c.pit_code} + 5'h01));
  assign ev_hit   = c.tick & c.pit_en & c.ev_pit_en &
                    ((presc_reg & low_mask({2'b00, c.ev_code} + PIT_EV_BASE))
                     == low_mask({2'b00, c.ev_code} + PIT_EV_BASE));

  // shared prescaler
  always_ff @(posedge ref_clk)
  begin
    if (srst || !run)
      presc_reg <= '0;
    else if (c.tick)
      presc_reg <= presc_reg + 15'h0001;
  end

  // count register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cnt_reg <= '0;
    else if (c.load)
      cnt_reg <= c.load_val;
    else if (cnt_step)
    begin
      if (cnt_reg == c.per)
        cnt_reg <= '0;
      else
        cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // event pulses
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      c.ovf_p    <= 1'b0;
      c.cmp_p    <= 1'b0;
      c.pit_p    <= 1'b0;
      c.pit_ev_p <= 1'b0;
    end
    else
    begin
      c.ovf_p    <= cnt_step & (cnt_reg == c.per);
      c.cmp_p    <= cnt_step & (cnt_reg == c.cmp);
      c.pit_p    <= pit_hit;
      c.pit_ev_p <= ev_hit;
    end
  end

  assign c.cnt = cnt_reg;
endmodule // rtcpc_core
`default_nettype wire

// ===== verilog/rtcpc_top.sv
// Purpose: real-time counter, periodic timer and oscillator control
// Assumes: apb slave, low-speed clock sampled on osc_pin_one_i
// Notes:   apb answers on the second access cycle
//
// Behaviour
// - periodic timer enables apart from counter
// - count increments per tick, compared continuously
// - compare event after count equals compare
// - overflow event after count equals period
// - overflow wraps count to zero
// - timer interrupt every 4 to 32768 periods
// - timer events every 64 to 8192 periods
// - one shared prescaler; division sets tick
// - interval field selects prescaler bit
// - select and startup ignore writes while enabled or stable shown
// - enable takes pin two when select zero, freezes select and startup
// - enable bit writable only via protect key
// - stable shown only while oscillator requested
// - select zero means crystal, writable without key
// - select one takes clock on pin one
// - counter writes apply two ticks later, busy
// - interval code zero off, fifteen reserved
// - wrap flag clears on writing one
//
// The APB slave port and the address map were decided locally.
`default_nettype none
module rtcpc_top
  import rtcpc_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator pins
  input  wire logic        osc_pin_one_i,
  output logic             osc_pin_one_o,
  output logic             osc_pin_one_oe,
  input  wire logic        osc_pin_two_i,
  output logic             osc_pin_two_o,
  output logic             osc_pin_two_oe,
  // oscillator requested as main clock
  input  wire logic        mclk_req,
  // interrupt requests and events
  output logic             cnt_irq,
  output logic             pit_irq,
  output logic             ovf_event,
  output logic             cmp_event,
  output logic             pit_event
);
  rtcpc_core_if cif ();

  logic [7:0]  counter_control_a_reg;
  logic [7:0]  counter_control_a_act_reg;
  logic [1:0]  intctrl_reg;
  logic [1:0]  flags_reg;
  logic [15:0] per_act_reg;
  logic [15:0] cmp_act_reg;
  logic [7:0]  evctrl_reg;
  logic [7:0]  pitctrl_reg;
  logic        pit_ie_reg;
  logic        pit_flag_reg;
  logic        osc_en_reg;
  logic        osc_stdby_reg;
  logic        osc_sel_reg;
  logic [1:0]  osc_crystal_startup_time_reg;
  logic [2:0]  prot_cnt_reg;
  logic [15:0] shadow_reg [4];
  logic [3:0]  busy_reg;
  logic [1:0]  stage_reg [4];
  logic [3:0]  apply;
  logic        pin_s1_reg;
  logic        pin_s2_reg;
  logic        pin_s3_reg;
  logic        tick;
  logic [16:0] start_cnt_reg;
  logic        stable_raw_reg;
  logic        stable_s1_reg;
  logic        stable_s2_reg;
  logic        requested;
  logic        stable_vis;
  logic        wr;
  logic        rd_ph;
  logic [31:0] rd_next;
  logic        err_next;
  logic [3:0]  busy_wr;
  logic [16:0] startup_need;

  // apb phases
  assign wr    = psel & penable & pready & pwrite;
  assign rd_ph = psel & penable & ~pready;

  // apb answer on second access cycle
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      pready <= 1'b0;
    else
      pready <= rd_ph;
  end

  // read decode
  always_comb
  begin
    rd_next  = '0;
    err_next = 1'b0;
    if (paddr == ADDR_COUNTER_CONTROL_A)
      rd_next[7:0] = counter_control_a_reg;
    else if (paddr == ADDR_STATUS)
      rd_next[3:0] = busy_reg;
    else if (paddr == ADDR_INTCTRL)
      rd_next[1:0] = intctrl_reg;
    else if (paddr == ADDR_INTERRUPT_FLAG_REGISTER)
      rd_next[1:0] = flags_reg;
    else if (paddr == ADDR_COUNT)
      rd_next[15:0] = cif.cnt;
    else if (paddr == ADDR_PERIOD)
      rd_next[15:0] = per_act_reg;
    else if (paddr == ADDR_COMPARE)
      rd_next[15:0] = cmp_act_reg;
    else if (paddr == ADDR_EVCTRL)
      rd_next[7:0] = evctrl_reg;
    else if (paddr == ADDR_PITCTRL)
      rd_next[7:0] = pitctrl_reg;
    else if (paddr == ADDR_PITINTEN)
      rd_next[0] = pit_ie_reg;
    else if (paddr == ADDR_PITFLAGS)
      rd_next[0] = pit_flag_reg;
    else if (paddr == ADDR_OSCCTRL)
    begin
      rd_next[OSC_EN_BIT]    = osc_en_reg;
      rd_next[OSC_STDBY_BIT] = osc_stdby_reg;
      rd_next[OSC_SEL_BIT]   = osc_sel_reg;
      rd_next[OSC_CRYSTAL_STARTUP_TIME_LSB +: 2] = osc_crystal_startup_time_reg;
    end
    else if (paddr == ADDR_MCLKSTAT)
      rd_next[OSC_STABLE_BIT] = stable_vis;
    else if (paddr == ADDR_PROTECT)
      rd_next[2:0] = prot_cnt_reg;
    else
      err_next = 1'b1;
  end

  // read data and error
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (rd_ph)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_next;
      pslverr <= err_next;
    end
    else
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  // plain control registers
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      intctrl_reg <= '0;
      evctrl_reg  <= '0;
      pitctrl_reg <= '0;
      pit_ie_reg  <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == ADDR_INTCTRL)
        intctrl_reg <= pwdata[1:0];
      else if (paddr == ADDR_EVCTRL)
        evctrl_reg <= pwdata[7:0];
      else if (paddr == ADDR_PITCTRL)
        pitctrl_reg <= pwdata[7:0];
      else if (paddr == ADDR_PITINTEN)
        pit_ie_reg <= pwdata[0];
    end
  end

  // writes that cross into the counter clock
  always_comb
  begin
    busy_wr = '0;
    if (wr)
    begin
      if (paddr == ADDR_COUNTER_CONTROL_A)
        busy_wr[BUSY_COUNTER_CONTROL_A] = 1'b1;
      else if (paddr == ADDR_COUNT)
        busy_wr[BUSY_CNT] = 1'b1;
      else if (paddr == ADDR_PERIOD)
        busy_wr[BUSY_PER] = 1'b1;
      else if (paddr == ADDR_COMPARE)
        busy_wr[BUSY_CMP] = 1'b1;
    end
  end

  // shadow, busy and two-tick delay per register
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      assign apply[gi] = busy_reg[gi] & tick &
                         (stage_reg[gi] == SYNC_TICKS - 2'h1);
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          busy_reg[gi]   <= 1'b0;
          stage_reg[gi]  <= '0;
          shadow_reg[gi] <= '0;
        end
        else if (busy_wr[gi])
        begin
          busy_reg[gi]   <= 1'b1;
          stage_reg[gi]  <= '0;
          shadow_reg[gi] <= pwdata[15:0];
        end
        else if (apply[gi])
          busy_reg[gi] <= 1'b0;
        else if (busy_reg[gi] && tick)
          stage_reg[gi] <= stage_reg[gi] + 2'h1;
      end
    end
  endgenerate

  // written control a and active copies
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      counter_control_a_reg     <= '0;
      counter_control_a_act_reg <= '0;
      per_act_reg   <= PERIOD_RST;
      cmp_act_reg   <= '0;
    end
    else
    begin
      if (busy_wr[BUSY_COUNTER_CONTROL_A])
        counter_control_a_reg <= pwdata[7:0];
      if (apply[BUSY_COUNTER_CONTROL_A])
        counter_control_a_act_reg <= shadow_reg[BUSY_COUNTER_CONTROL_A][7:0];
      if (apply[BUSY_PER])
        per_act_reg <= shadow_reg[BUSY_PER];
      if (apply[BUSY_CMP])
        cmp_act_reg <= shadow_reg[BUSY_CMP];
    end
  end

  // counter flags, set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      flags_reg    <= '0;
      pit_flag_reg <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == WRAP_BIT) ? cif.ovf_p : cif.cmp_p)
          flags_reg[i] <= 1'b1;
        else if (wr && paddr == ADDR_INTERRUPT_FLAG_REGISTER && pwdata[i])
          flags_reg[i] <= 1'b0;
      end
      if (cif.pit_p)
        pit_flag_reg <= 1'b1;
      else if (wr && paddr == ADDR_PITFLAGS && pwdata[0])
        pit_flag_reg <= 1'b0;
    end
  end

  // interrupt and event outputs
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cnt_irq   <= 1'b0;
      pit_irq   <= 1'b0;
      ovf_event <= 1'b0;
      cmp_event <= 1'b0;
      pit_event <= 1'b0;
    end
    else
    begin
      cnt_irq   <= |(flags_reg & intctrl_reg);
      pit_irq   <= pit_flag_reg & pit_ie_reg;
      ovf_event <= cif.ovf_p & evctrl_reg[WRAP_BIT];
      cmp_event <= cif.cmp_p & evctrl_reg[CMP_BIT];
      pit_event <= cif.pit_ev_p;
    end
  end

  // protect key opens a short window for the enable bit
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      prot_cnt_reg <= '0;
    else if (wr && paddr == ADDR_PROTECT && pwdata[7:0] == PROT_KEY)
      prot_cnt_reg <= PROT_WIN;
    else if (wr && paddr == ADDR_OSCCTRL)
      prot_cnt_reg <= '0;
    else if (prot_cnt_reg != 3'h0)
      prot_cnt_reg <= prot_cnt_reg - 3'h1;
  end

  // oscillator control
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      osc_en_reg    <= 1'b0;
      osc_stdby_reg <= 1'b0;
      osc_sel_reg   <= 1'b0;
      osc_crystal_startup_time_reg  <= '0;
    end
    else if (wr && paddr == ADDR_OSCCTRL)
    begin
      osc_stdby_reg <= pwdata[OSC_STDBY_BIT];
      if (prot_cnt_reg != 3'h0)
        osc_en_reg <= pwdata[OSC_EN_BIT];
      if (!osc_en_reg && !stable_vis)
      begin
        osc_sel_reg  <= pwdata[OSC_SEL_BIT];
        osc_crystal_startup_time_reg <= pwdata[OSC_CRYSTAL_STARTUP_TIME_LSB +: 2];
      end
    end
  end

  // pin one sampler; first stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= osc_pin_one_i;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign tick = osc_en_reg & pin_s2_reg & ~pin_s3_reg;

  // pin two taken over while enabled with select zero; pin one never driven
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      osc_pin_one_o  <= 1'b0;
      osc_pin_one_oe <= 1'b0;
      osc_pin_two_o  <= 1'b0;
      osc_pin_two_oe <= 1'b0;
    end
    else
    begin
      osc_pin_one_o  <= 1'b0;
      osc_pin_one_oe <= 1'b0;
      osc_pin_two_o  <= ~pin_s2_reg & osc_en_reg & ~osc_sel_reg;
      osc_pin_two_oe <= osc_en_reg & ~osc_sel_reg;
    end
  end

  // start-up count of low-speed edges
  assign startup_need = STARTUP_MIN << {osc_crystal_startup_time_reg, 1'b0};

  always_ff @(posedge ref_clk)
  begin
    if (srst || !osc_en_reg)
    begin
      start_cnt_reg  <= '0;
      stable_raw_reg <= 1'b0;
    end
    else if (tick && !stable_raw_reg)
    begin
      start_cnt_reg <= start_cnt_reg + 17'h00001;
      if (start_cnt_reg + 17'h00001 >= startup_need)
        stable_raw_reg <= 1'b1;
    end
  end

  // stable flag synchroniser
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      stable_s1_reg <= 1'b0;
      stable_s2_reg <= 1'b0;
    end
    else
    begin
      stable_s1_reg <= stable_raw_reg;
      stable_s2_reg <= stable_s1_reg;
    end
  end

  assign requested  = mclk_req | counter_control_a_act_reg[COUNTER_CONTROL_A_EN_BIT] |
                      pitctrl_reg[PIT_EN_BIT];
  assign stable_vis = stable_s2_reg & requested;

  // core settings
  assign cif.tick      = tick;
  assign cif.rtc_en    = counter_control_a_act_reg[COUNTER_CONTROL_A_EN_BIT];
  assign cif.pit_en    = pitctrl_reg[PIT_EN_BIT];
  assign cif.ev_pit_en = evctrl_reg[PITEV_BIT];
  assign cif.presc     = counter_control_a_act_reg[COUNTER_CONTROL_A_PRESC_LSB +: 4];
  assign cif.pit_code  = pitctrl_reg[PIT_CODE_LSB +: 4];
  assign cif.ev_code   = evctrl_reg[EVSEL_LSB +: 3];
  assign cif.per       = per_act_reg;
  assign cif.cmp       = cmp_act_reg;
  assign cif.load      = apply[BUSY_CNT];
  assign cif.load_val  = shadow_reg[BUSY_CNT];

  rtcpc_core u_core (
    .ref_clk (ref_clk),
    .srst    (srst),
    .c       (cif)
  );
endmodule // rtcpc_top
`default_nettype wire

// ===== test/rtcpc_osc_model.sv
// Purpose: low-speed clock source on oscillator pin one
// Assumes: runs only while run is high
// Notes:   stands low when stopped; half period in ref_clk cycles
`default_nettype none
module rtcpc_osc_model #(
  parameter int HALF = 2
) (
  // clock
  input  wire logic ref_clk,
  // control and pin
  input  wire logic run,
  output logic      pin = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  // toggles every HALF cycles, held low when stopped
  always @(posedge ref_clk)
  begin
    if (!run)
    begin
      pin <= 1'b0;
      n   <= 0;
    end
    else if (n == HALF - 1)
    begin
      pin <= !pin;
      n   <= 0;
    end
    else
      n <= n + 1;
  end
endmodule // rtcpc_osc_model
`default_nettype wire

// ===== test/rtcpc_checker.sv
// Purpose: port assertions for the real-time counter block
// Assumes: one clock domain, synchronous reset
// Notes:   low-speed ticks come at least four ref_clk apart
`default_nettype none
module rtcpc_checker
  import rtcpc_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and events
  input wire logic        osc_pin_one_i,
  input wire logic        osc_pin_one_oe,
  input wire logic        osc_pin_two_o,
  input wire logic        osc_pin_two_oe,
  input wire logic        ovf_event,
  input wire logic        cmp_event,
  input wire logic        pit_event
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  logic wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  AST_APB_WAIT: assert property (s_setup |-> s_answer)
    else $error("pready not on second access cycle");
  AST_APB_ONE: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access or longer than one cycle");
  AST_SLVERR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  AST_OVF_GAP: assert property (ovf_event |=> !ovf_event [*3])
    else $error("overflow events closer than one tick");
  AST_CMP_GAP: assert property (cmp_event |=> !cmp_event [*3])
    else $error("compare events closer than one tick");
  AST_PIT_GAP: assert property (pit_event |=> !pit_event [*8])
    else $error("timer events too close");
  AST_OSC_OE: assert property ($changed(osc_pin_two_oe) |->
    $past(wr_done) || $past(wr_done, 2))
    else $error("pin two enable changed without a write");
  AST_PIN_ONE_IN: assert property (!osc_pin_one_oe)
    else $error("pin one driven");
  AST_PIN_TWO_DRV: assert property (osc_pin_two_o ==
    (osc_pin_two_oe && !$past(osc_pin_one_i, 3)))
    else $error("pin two not inverted pin one");
endmodule // rtcpc_checker
bind rtcpc_top rtcpc_checker u_chk (
  .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .osc_pin_one_i(osc_pin_one_i), .osc_pin_one_oe(osc_pin_one_oe),
  .osc_pin_two_o(osc_pin_two_o),
  .osc_pin_two_oe(osc_pin_two_oe), .ovf_event(ovf_event),
  .cmp_event(cmp_event), .pit_event(pit_event)
);
`default_nettype wire

// ===== test/tb.sv
// Purpose: register-level test of counter, timer and oscillator
// Assumes: source clock ticks every four ref_clk cycles
// Notes:   times measured in ref_clk cycles from sampled edges
`default_nettype none
module tb;
  import rtcpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0, srst = 1, mreq = 0, ext_on = 0;
  logic        psel = 0, penable = 0, pwrite = 0, serr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, pin, o2e, cnt_irq, pit_irq;
  logic        ovf_ev, cmp_ev, pit_ev;
  int          err_total = 0, num_checks = 0, cyc = 0, tnow, t0;
  wire logic [3:0] sig = {pit_irq, pit_ev, cmp_ev, ovf_ev};
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  rtcpc_top dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_pin_one_i(pin), .osc_pin_one_o(), .osc_pin_one_oe(),
    .osc_pin_two_i(1'b0), .osc_pin_two_o(), .osc_pin_two_oe(o2e),
    .mclk_req(mreq), .cnt_irq(cnt_irq), .pit_irq(pit_irq),
    .ovf_event(ovf_ev), .cmp_event(cmp_ev), .pit_event(pit_ev));
  rtcpc_osc_model #(.HALF(2)) u_osc (.ref_clk(ref_clk),
    .run(o2e | ext_on), .pin(pin));
  task automatic stop_test();
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; more keeps psel for a back-to-back setup
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input bit more = 0);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      err_total++;
      stop_test();
    end
    rd = prdata;
    serr = pslverr;
    penable <= 1'b0;
    if (!more)
    begin
      psel <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task automatic wait_sig(input int i, input logic v);
    int k;
    k = 0;
    while (sig[i] !== v && k < 5000)
    begin
      @(posedge ref_clk);
      k++;
    end
    tnow = cyc;
    if (k >= 5000)
    begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    int k;
    k = 0;
    do
    begin
      apb(0, a, 0);
      k++;
    end while ((rd & m) !== v && k < 400);
    chk(rd & m, v);
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    apb(0, ADDR_PERIOD, 0);
    chk(rd, 32'h0000ffff);
    apb(0, ADDR_MCLKSTAT, 0);
    chk(rd, 32'h0);
    apb(0, 8'h3c, 0);
    chk(32'(serr), 32'h1);
    // enable crystal: unkeyed write refused, keyed accepted
    apb(1, ADDR_OSCCTRL, 32'h01);
    apb(0, ADDR_OSCCTRL, 0);
    chk(rd, 32'h0);
    apb(1, ADDR_PROTECT, 32'(PROT_KEY), 1);
    apb(1, ADDR_OSCCTRL, 32'h01);
    @(posedge ref_clk);
    chk(32'(o2e), 32'h1);
    apb(1, ADDR_PROTECT, 32'(PROT_KEY), 1);
    apb(1, ADDR_OSCCTRL, 32'h05);
    apb(0, ADDR_OSCCTRL, 0);
    chk(rd, 32'h01);
    mreq <= 1'b1;
    poll(ADDR_MCLKSTAT, 32'h40, 32'h40);
    mreq <= 1'b0;
    apb(0, ADDR_MCLKSTAT, 0);
    chk(rd & 32'h40, 32'h0);
    // counter: period 3, compare 1, divide by one
    apb(1, ADDR_PERIOD, 32'h3);
    apb(0, ADDR_STATUS, 0);
    chk(rd, 32'h4);
    apb(1, ADDR_COMPARE, 32'h1);
    apb(1, ADDR_INTCTRL, 32'h1);
    apb(1, ADDR_EVCTRL, 32'h3);
    apb(1, ADDR_COUNTER_CONTROL_A, 32'h1);
    poll(ADDR_STATUS, 32'hf, 32'h0);
    apb(0, ADDR_MCLKSTAT, 0);
    chk(rd & 32'h40, 32'h40);
    wait_sig(1, 1);
    t0 = tnow;
    wait_sig(0, 1);
    chk(tnow - t0, 8);
    t0 = tnow;
    wait_sig(0, 0);
    chk(32'(cnt_irq), 32'h1);
    wait_sig(0, 1);
    chk(tnow - t0, 16);
    apb(1, ADDR_COUNTER_CONTROL_A, 32'h0);
    poll(ADDR_STATUS, 32'hf, 32'h0);
    apb(0, ADDR_INTERRUPT_FLAG_REGISTER, 0);
    chk(rd, 32'h3);
    apb(1, ADDR_INTERRUPT_FLAG_REGISTER, 32'h3);
    apb(0, ADDR_INTERRUPT_FLAG_REGISTER, 0);
    chk(rd, 32'h0);
    chk(32'(cnt_irq), 32'h0);
    // periodic timer alone, counter off
    apb(1, ADDR_PITINTEN, 32'h1);
    for (int k = 1; k <= 3; k++)
    begin
      apb(1, ADDR_PITCTRL, (k << 3) | 1);
      for (int j = 0; j < 2; j++)
      begin
        t0 = tnow;
        apb(1, ADDR_PITFLAGS, 32'h1);
        wait_sig(3, 0);
        wait_sig(3, 1);
      end
      chk(tnow - t0, 4 << (k + 1));
    end
    for (int e = 0; e < 2; e++)
    begin
      apb(1, ADDR_EVCTRL, (e << 4) | 4);
      wait_sig(2, 1);
      t0 = tnow;
      wait_sig(2, 0);
      wait_sig(2, 1);
      chk(tnow - t0, 256 << e);
    end
    for (int c = 0; c < 2; c++)
    begin
      apb(1, ADDR_PITCTRL, c ? 32'h79 : 32'h01);
      apb(1, ADDR_PITFLAGS, 32'h1);
      repeat (300) @(posedge ref_clk);
      chk(32'(pit_irq), 32'h0);
    end
    // change source: disable, wait unstable, select external
    apb(1, ADDR_PITCTRL, 32'h0);
    mreq <= 1'b1;
    apb(1, ADDR_PROTECT, 32'(PROT_KEY), 1);
    apb(1, ADDR_OSCCTRL, 32'h0);
    poll(ADDR_MCLKSTAT, 32'h40, 32'h0);
    apb(1, ADDR_OSCCTRL, 32'h04);
    apb(0, ADDR_OSCCTRL, 0);
    chk(rd, 32'h04);
    ext_on <= 1'b1;
    apb(1, ADDR_PROTECT, 32'(PROT_KEY), 1);
    apb(1, ADDR_OSCCTRL, 32'h05);
    @(posedge ref_clk);
    chk(32'(o2e), 32'h0);
    poll(ADDR_MCLKSTAT, 32'h40, 32'h40);
    stop_test();
  end
endmodule // tb
`default_nettype wire
